// file: src/bpsr_level_reg.v
`timescale 1ns/1ps
`include "bpsr_regs.vh"

// Holds the power level and the scratch bit; only the core reset clears it
module bpsr_level_reg (
    input wire clk_i,
    input wire rst_i,
    input wire wr_low_i,
    input wire wr_high_i,
    input wire [1:0] level_wdata_i,
    input wire scratch_wdata_i,
    output reg [1:0] level_o,
    output reg scratch_o
);

    // No state change resets anything else: context survives D3 to D0
    always @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= `BPSR_LVL_D0;
            scratch_o <= 1'b0;
        end else begin
            if (wr_low_i) begin
                level_o <= level_wdata_i;
            end
            if (wr_high_i) begin
                scratch_o <= scratch_wdata_i;
            end
        end
    end

endmodule

// file: src/bpsr_regs.vh
`ifndef BPSR_REGS_VH
`define BPSR_REGS_VH

// Configuration dword holding the power control/status group
`define BPSR_DWORD_ADDR 6'h15
// Byte offsets of the three registers
`define BPSR_PCS_OFFSET 8'h54
`define BPSR_EXT_OFFSET 8'h56
`define BPSR_DATA_OFFSET 8'h57
// Reset values
`define BPSR_PCS_RESET 16'h0000
`define BPSR_EXT_RESET 8'h40
`define BPSR_DATA_RESET 8'h00
// Answer driven when no read hits, and its width
`define BPSR_RDATA_IDLE 32'h00000000
`define BPSR_WORD_BITS 32
// Power level encodings
`define BPSR_LVL_D0 2'h0
`define BPSR_LVL_D1 2'h1
`define BPSR_LVL_D2 2'h2
`define BPSR_LVL_D3 2'h3
// Field positions within the control/status half
`define BPSR_LVL_LSB 0
`define BPSR_LVL_MSB 1
`define BPSR_CTX_BIT 3
`define BPSR_WAKE_EN_BIT 8
// Field positions within the extension byte
`define BPSR_CLK_STOP_BIT 7
`define BPSR_B2_BIT 6
// Values of the read-only fields
`define BPSR_WAKE_FLAG_VAL 1'h0
`define BPSR_SCALE_VAL 2'h0
`define BPSR_SELECT_VAL 4'h0
`define BPSR_RSVD_HIGH_VAL 4'h0
`define BPSR_RSVD_LOW_VAL 1'h0
`define BPSR_B2_VALUE 1'h1
`define BPSR_EXT_RSVD_VAL 6'h00
// Byte lanes
`define BPSR_BE_LOW 0
`define BPSR_BE_HIGH 1

`endif

// file: src/bpsr_top.v
`timescale 1ns/1ps
`include "bpsr_regs.vh"

// What this block does
// - Power level: 00 D0..11 D3hot, reset D0
// - Writing level changes state; read returns it
// - D3hot to D0 keeps all configuration state
// - Context flag reads 0 when revision select 0
// - Context flag reads 1 when revision select 1
// - Scratch wake bit: plain storage, resets 0
// - Wake event flag bit 15 reads 0
// - Scale and select fields read zero
// - Reserved control bits ignore writes, read zero
// - Clock stop flag mirrors secondary_clock_stop_setting_i
// - Secondary clocks stop in D3 when flag set
// - Bus B2 indicator reads constant one
// - Extension bits 5:0 read zero
// - Data byte always reads zero
module bpsr_top (
    input wire clk_i,
    input wire rst_i,
    input wire cfg_sel_i,
    input wire cfg_wr_i,
    input wire cfg_rd_i,
    input wire [5:0] cfg_dword_i,
    input wire [3:0] cfg_be_i,
    input wire [31:0] cfg_wdata_i,
    input wire revision_select_bit_i,
    input wire secondary_clock_stop_setting_i,
    output reg [31:0] cfg_rdata_o,
    output reg cfg_hit_o,
    output reg [1:0] device_power_level_o,
    output reg sec_clk_run_o
);

    // Request decode
    wire any_req;
    wire dword_match;
    wire sel_hit;
    wire rd_hit;
    wire wr_hit;
    wire wr_low;
    wire wr_high;

    // Write data picked out of the dword
    wire [1:0] level_wdata;
    wire scratch_wdata;

    // Fields held in the level register
    wire [1:0] level;
    wire scratch;

    // Read-only control/status fields
    wire wake_flag;
    wire [1:0] meas_scale;
    wire [3:0] meas_select;
    wire [3:0] rsvd_high;
    wire ctx_flag;
    wire rsvd_low;

    // Extension byte fields
    wire clk_stop_flag;
    wire b2_flag;
    wire [5:0] ext_rsvd;

    // Byte views of the answered dword
    wire [15:0] cs_half;
    wire [7:0] ext_byte;
    wire [7:0] data_byte;
    wire [31:0] rd_word;
    wire [31:0] idle_word;

    // Clock gating inputs
    wire level_is_d3;
    wire stop_in_d3;

    // Next values of the registered outputs
    wire [31:0] rdata_d;
    reg hit_d;
    reg [1:0] level_out_d;
    reg clk_run_d;

    // One dword answers; every other index stays silent
    assign dword_match = (cfg_dword_i == `BPSR_DWORD_ADDR);
    assign sel_hit = cfg_sel_i && dword_match;
    assign any_req = cfg_rd_i || cfg_wr_i;

    // Read and write decoded apart so each keeps its own effect
    assign rd_hit = sel_hit && cfg_rd_i;
    assign wr_hit = sel_hit && cfg_wr_i;

    // Lanes 2 and 3 carry only read-only bytes, so their writes drop
    assign wr_low = wr_hit && cfg_be_i[`BPSR_BE_LOW];
    assign wr_high = wr_hit && cfg_be_i[`BPSR_BE_HIGH];

    // Writable bits, taken from their places in the dword
    assign level_wdata = cfg_wdata_i[`BPSR_LVL_MSB:`BPSR_LVL_LSB];
    assign scratch_wdata = cfg_wdata_i[`BPSR_WAKE_EN_BIT];

    // Level and scratch storage; no power state change resets it
    bpsr_level_reg u_level (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_low_i(wr_low),
        .wr_high_i(wr_high),
        .level_wdata_i(level_wdata),
        .scratch_wdata_i(scratch_wdata),
        .level_o(level),
        .scratch_o(scratch)
    );

    // Fixed status fields: nothing stands behind them in this bridge
    assign wake_flag = `BPSR_WAKE_FLAG_VAL;
    assign meas_scale = `BPSR_SCALE_VAL;
    assign meas_select = `BPSR_SELECT_VAL;

    // Reserved bits have no storage, so writes cannot reach them
    assign rsvd_high = `BPSR_RSVD_HIGH_VAL;
    assign rsvd_low = `BPSR_RSVD_LOW_VAL;

    // Context kept is claimed only in the newer revision mode
    assign ctx_flag = revision_select_bit_i;

    // Control/status half, most significant field first
    assign cs_half = {
        wake_flag,
        meas_scale,
        meas_select,
        scratch,
        rsvd_high,
        ctx_flag,
        rsvd_low,
        level
    };

    // Clock policy mirrors the setting; bus state in D3 is fixed
    assign clk_stop_flag = secondary_clock_stop_setting_i;
    assign b2_flag = `BPSR_B2_VALUE;
    assign ext_rsvd = `BPSR_EXT_RSVD_VAL;

    // Extension byte, flags on top
    assign ext_byte = {
        clk_stop_flag,
        b2_flag,
        ext_rsvd
    };

    // Data byte is not implemented and reads a constant
    assign data_byte = `BPSR_DATA_RESET;

    // Dword in configuration byte order: data, extension, control
    assign rd_word = {
        data_byte,
        ext_byte,
        cs_half
    };
    assign idle_word = `BPSR_RDATA_IDLE;

    // Hit flag covers reads and writes alike
    always @* begin
        hit_d = sel_hit && any_req;
    end

    // Per-bit gate; idle answer is zero so no stale read lingers
    genvar b;
    generate
        for (b = 0; b < `BPSR_WORD_BITS; b = b + 1) begin : g_rd_gate
            assign rdata_d[b] = rd_hit ? rd_word[b] : idle_word[b];
        end
    endgenerate

    // Registered read data, one cycle after the request is taken
    always @(posedge clk_i) begin
        if (rst_i) begin
            cfg_rdata_o <= `BPSR_RDATA_IDLE;
        end else begin
            cfg_rdata_o <= rdata_d;
        end
    end

    // Hit flag stands for exactly one cycle per taken access
    always @(posedge clk_i) begin
        if (rst_i) begin
            cfg_hit_o <= 1'b0;
        end else begin
            cfg_hit_o <= hit_d;
        end
    end

    // Gating uses the stored level, not the export that lags it
    assign level_is_d3 = (level == `BPSR_LVL_D3);
    assign stop_in_d3 = secondary_clock_stop_setting_i && level_is_d3;

    // Level export follows the stored level
    always @* begin
        level_out_d = level;
    end

    // Run drops only in D3 with stopping enabled
    always @* begin
        clk_run_d = 1'b1;
        if (stop_in_d3) begin
            clk_run_d = 1'b0;
        end
    end

    // Level export trails the register by one cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            device_power_level_o <= `BPSR_LVL_D0;
        end else begin
            device_power_level_o <= level_out_d;
        end
    end

    // Clocks run out of reset; they stop only once D3 is reached
    always @(posedge clk_i) begin
        if (rst_i) begin
            sec_clk_run_o <= 1'b1;
        end else begin
            sec_clk_run_o <= clk_run_d;
        end
    end

endmodule

// file: testbench/bpsr_host.sv
`timescale 1ns/1ps
// Host side: general control bits, settled one cycle after a change
module bpsr_host(input wire clk_i, input wire [1:0] set_i,
    output reg rev_o = 1'b0, output reg stop_o = 1'b0);
// Registered like a real config write, never seen in the same cycle
always @(posedge clk_i) begin
    {rev_o, stop_o} <= set_i;
end
endmodule

// file: testbench/bpsr_props.sv
`timescale 1ns/1ps
module bpsr_props(input wire clk_i, rst_i, cfg_sel_i, cfg_wr_i, cfg_rd_i,
input wire [5:0] cfg_dword_i, input wire [3:0] cfg_be_i,
input wire [31:0] cfg_wdata_i, cfg_rdata_o,
input wire [1:0] device_power_level_o, input wire revision_select_bit_i,
input wire secondary_clock_stop_setting_i, cfg_hit_o, sec_clk_run_o);
// Decoded requests
wire hit = cfg_sel_i && cfg_dword_i == 6'h15 && (cfg_rd_i || cfg_wr_i);
wire rdh = hit && cfg_rd_i;
wire lw = hit && cfg_wr_i && cfg_be_i[0];
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
sequence s_lw; lw ##1 1; endsequence
property p_hit; hit |=> cfg_hit_o; endproperty
a_hit: assert property (p_hit) else $error("no hit");
property p_zero; !rdh |=> cfg_rdata_o == 32'h0; endproperty
a_zero: assert property (p_zero) else $error("stray data");
property p_fix; rdh |=> (cfg_rdata_o & 32'h0000_fef4) == 32'h0;
endproperty
a_fix: assert property (p_fix) else $error("fixed bits");
property p_ext; rdh |=> (cfg_rdata_o & 32'hff7f_0000) == 32'h0040_0000;
endproperty
a_ext: assert property (p_ext) else $error("ext bits");
property p_ctx; rdh ##1 $stable(revision_select_bit_i) |->
cfg_rdata_o[3] == revision_select_bit_i; endproperty
a_ctx: assert property (p_ctx) else $error("context flag");
property p_stp; rdh ##1 $stable(secondary_clock_stop_setting_i) |->
cfg_rdata_o[23] == secondary_clock_stop_setting_i; endproperty
a_stp: assert property (p_stp) else $error("stop flag");
property p_lvl; s_lw |=> device_power_level_o == $past(cfg_wdata_i[1:0], 2);
endproperty
a_lvl: assert property (p_lvl) else $error("level");
property p_clk; $stable(secondary_clock_stop_setting_i) |-> sec_clk_run_o ==
!(secondary_clock_stop_setting_i && device_power_level_o == 2'h3); endproperty
a_clk: assert property (p_clk) else $error("clock run");
property p_keep; !lw |=> ##1 $stable(device_power_level_o); endproperty
a_keep: assert property (p_keep) else $error("level moved");
endmodule
bind bpsr_top bpsr_props i_props (.*);

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
reg clk_i = 0, rst_i = 1, cfg_sel_i = 0, cfg_wr_i = 0, cfg_rd_i = 0;
reg [5:0] cfg_dword_i = 6'h15;
reg [3:0] cfg_be_i = 4'h0;
reg [31:0] cfg_wdata_i = 32'h0;
reg [1:0] set = 2'h0;
wire revision_select_bit_i, secondary_clock_stop_setting_i, cfg_hit_o;
wire sec_clk_run_o;
wire [31:0] cfg_rdata_o;
wire [1:0] device_power_level_o;
integer errors = 0, total_checks = 0, k;
initial forever #5 clk_i = ~clk_i;
bpsr_host i_host(.clk_i, .set_i(set), .rev_o(revision_select_bit_i),
    .stop_o(secondary_clock_stop_setting_i));
bpsr_top i_dut(.*);
task chk(input [31:0] s, e, input [23:0] n);
begin
    total_checks = total_checks + 1;
    if (s !== e) begin
        errors = errors + 1;
        $display("mismatch %s exp %h got %h", n, e, s);
    end
end
endtask
task close_out;
begin
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
end
endtask
// One config access, answer checked the cycle after it is taken
task acc(input w, input [31:0] d, input [3:0] b, input h, input [31:0] e);
begin
    @(negedge clk_i);
    {cfg_sel_i, cfg_wr_i, cfg_rd_i} = {1'b1, w, !w};
    {cfg_wdata_i, cfg_be_i} = {d, b};
    @(negedge clk_i);
    {cfg_sel_i, cfg_wr_i, cfg_rd_i} = 3'h0;
    chk(cfg_hit_o, h, "hit");
    chk(cfg_rdata_o, e, "rd");
end
endtask
initial begin
    repeat (5) @(posedge clk_i);
    @(negedge clk_i) rst_i = 0;
    acc(0, 0, 4'hf, 1, 32'h0040_0000);
    set = 2'h3;
    acc(1, 32'hffff_ffff, 4'hf, 1, 0);
    acc(0, 0, 4'hf, 1, 32'h00c0_010b);
    for (k = 0; k < 4; k = k + 1) begin
        acc(1, k, 4'h1, 1, 0);
        @(negedge clk_i);
        chk(device_power_level_o, k, "lvl");
        chk(sec_clk_run_o, k != 3, "run");
        acc(0, 0, 4'hf, 1, 32'h00c0_0108 | k);
    end
    set = 2'h0;
    acc(1, 0, 4'h2, 1, 0);
    acc(0, 0, 4'hf, 1, 32'h0040_0003);
    chk(sec_clk_run_o, 1, "run");
    cfg_dword_i = 6'h16;
    acc(0, 0, 4'hf, 0, 0);
    close_out;
end
// Whole run is about 40 cycles; this limit only cuts a hang
initial begin
    #20000;
    errors = errors + 1;
    close_out;
end
endmodule
